// ===== src/dac_ctrl_pkg.sv
// Purpose: Shared constants and types for the converter control front end.
// Assumes: APB slave, 32-bit data, byte offsets as printed.
// Notes: Field positions and the control, calibration and bias reset values live here.
package dac_ctrl_pkg;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_CH0CTRL = 12'h008;
  localparam logic [11:0] OFF_CH1CTRL = 12'h00C;
  localparam logic [11:0] OFF_IEN = 12'h010;
  localparam logic [11:0] OFF_IF = 12'h014;
  localparam logic [11:0] OFF_IFS = 12'h018;
  localparam logic [11:0] OFF_IFC = 12'h01C;
  localparam logic [11:0] OFF_CH0VAL = 12'h020;
  localparam logic [11:0] OFF_CH1VAL = 12'h024;
  localparam logic [11:0] OFF_JOINT = 12'h028;
  localparam logic [11:0] OFF_CAL = 12'h02C;
  localparam logic [11:0] OFF_BIAS = 12'h030;
  localparam logic [11:0] OFF_AMPCTRL = 12'h054;
  localparam logic [11:0] OFF_AMPOFS = 12'h058;
  localparam logic [11:0] OFF_AMP0MUX = 12'h05C;
  localparam logic [11:0] OFF_AMP1MUX = 12'h060;
  localparam logic [11:0] OFF_AMP2MUX = 12'h064;
  // Control register field positions.
  localparam int CTRL_DIFFERENTIAL_PAIR = 0;
  localparam int CTRL_SINE = 1;
  localparam int CTRL_CONV_LO = 2;
  localparam int CTRL_OUT_LO = 4;
  localparam int CTRL_OUTEN = 6;
  localparam int CTRL_RST0 = 7;
  localparam int CTRL_REF_LO = 8;
  localparam int CTRL_DIV_LO = 16;
  localparam int CTRL_RFR_LO = 20;
  localparam logic [31:0] CTRL_MASK = 32'h0037_03FF;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0010;
  // Channel control field positions.
  localparam int CH_EN = 0;
  localparam int CH_RFR = 1;
  localparam int CH_TRIGEN = 2;
  localparam int CH_SEL_LO = 4;
  localparam logic [31:0] CH_MASK = 32'h0000_0077;
  localparam logic [31:0] IF_MASK = 32'h0000_0033;
  localparam logic [31:0] VAL_MASK = 32'h0000_0FFF;
  localparam logic [31:0] CAL_RESET = 32'h0000_0000;
  localparam logic [31:0] BIAS_RESET = 32'h0000_0000;
  localparam logic [1:0] REF_BG1V25 = 2'h0;
  localparam logic [1:0] REF_BG2V5 = 2'h1;
  localparam logic [1:0] REF_SUPPLY = 2'h2;
  localparam int SINE_STEPS = 16;
  localparam int DIV_W = 7;
  localparam int RFR_BASE = 8;
  typedef enum logic [1:0] {
    CONV_CONTINUOUS = 2'b00,
    CONV_SAMPLE_HOLD = 2'b01,
    CONV_SAMPLE_OFF = 2'b10
  } conv_style_t;
  typedef struct packed {
    logic pending;
    logic start;
    logic [11:0] value;
  } chan_out_t;
endpackage

// ===== src/dac_digital_control.sv
// Purpose: Digital control and APB register front end of a two-channel converter.
// Assumes: One clock pclk at 40 MHz; event lines are asynchronous and synchronised here.
// Notes: Analog core sees value, start strobes, enables and mode fields on registered outputs.
// Notes on behaviour
// - Refresh period is 8, 16, 32 or 64 divided clock cycles by code.
// - Only channels with auto rewrite set get periodic refreshes.
// - Converter clock is peripheral clock divided by two to the exponent.
// - Reference code 0 is 1.25 V, 1 is 2.5 V, 2 supply; resets 0.
// - Divider restarts on each channel 0 start when restart bit set.
// - Outputs enabled always, or follow channel 1 event line when gated.
// - Routing 0 off, 1 pin, 2 internal, 3 both; resets to 1.
// - Conversion style 0 continuous, 1 sample hold, 2 shut off; resets 0.
// - Pending bit sets on value write to an enabled channel, clears when conversion consumes it; write wins same cycle.
// - Trigger selector bits 6:4 picks one of eight event lines.
// - Trigger enable clear: start on writes; set: event line replaces writes as start source.
// - Writing one to flag-set register sets the matching flag.
// - Writing one to flag-clear register clears the matching flag.
// - Waveform mode feeds channel 0 a 16-step sine while event line high.
// - Differential pair sources both outputs from channel 0 value.
// - Joint value write loads both values and starts enabled channels whose trigger enable is clear.
`timescale 1ns/1ps
`default_nettype none
module dac_digital_control
  import dac_ctrl_pkg::*;
(
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Asynchronous event lines
  input wire logic [7:0] event_line,
  // Converter core side
  output chan_out_t ch0_out,
  output chan_out_t ch1_out,
  output logic [1:0] chan_enable,
  output logic out_enable,
  output logic [1:0] output_routing,
  output logic [1:0] reference_sel,
  output conv_style_t conversion_style,
  output logic differential_pair,
  output logic converter_clk_en,
  output logic [1:0] conv_done
);
  // ==========================================================
  // Event line synchronisers
  logic [7:0] ev_meta_q;
  logic [7:0] ev_sync_q;
  logic [7:0] ev_prev_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ev_meta_q <= 8'h00;
      ev_sync_q <= 8'h00;
      ev_prev_q <= 8'h00;
    end
    else
    begin
      ev_meta_q <= event_line;
      ev_sync_q <= ev_meta_q;
      ev_prev_q <= ev_sync_q;
    end
  end
  logic [7:0] ev_rise;
  assign ev_rise = ev_sync_q & ~ev_prev_q;

  // ==========================================================
  // Register bank
  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] chctl_q [2];
  logic [31:0] chctl_d [2];
  logic [31:0] ien_q, ien_d, flags_q, flags_d;
  logic [31:0] cal_q, cal_d, bias_q, bias_d;
  logic [31:0] amp_q [5];
  logic [31:0] amp_d [5];
  logic [11:0] val_q [2];
  logic [11:0] val_d [2];
  logic [1:0] pend_q, pend_d;
  logic [31:0] prdata_d;
  logic wr, rd, unmapped;
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;

  logic [1:0] rfr_code;
  logic [3:0] div_exp;
  assign rfr_code = ctrl_q[CTRL_RFR_LO +: 2];
  assign div_exp = {1'b0, ctrl_q[CTRL_DIV_LO +: 3]};

  // Start requests per channel, computed below.
  logic [1:0] data_start, trig_start, rfr_start, start;
  logic [1:0] chan_en;
  assign chan_en = {chctl_q[1][CH_EN], chctl_q[0][CH_EN]};

  always_comb
  begin
    ctrl_d = ctrl_q;
    chctl_d = chctl_q;
    ien_d = ien_q;
    cal_d = cal_q;
    bias_d = bias_q;
    amp_d = amp_q;
    val_d = val_q;
    data_start = 2'b00;
    unmapped = 1'b0;
    if (wr)
    begin
      case (paddr)
        OFF_CTRL: ctrl_d = pwdata & CTRL_MASK;
        OFF_CH0CTRL: chctl_d[0] = pwdata & CH_MASK;
        OFF_CH1CTRL: chctl_d[1] = pwdata & CH_MASK;
        OFF_IEN: ien_d = pwdata & IF_MASK;
        OFF_CH0VAL:
        begin
          val_d[0] = pwdata[11:0];
          data_start[0] = 1'b1;
        end
        OFF_CH1VAL:
        begin
          val_d[1] = pwdata[11:0];
          data_start[1] = 1'b1;
        end
        OFF_JOINT:
        begin
          val_d[0] = pwdata[11:0];
          val_d[1] = pwdata[27:16];
          data_start = 2'b11;
        end
        OFF_CAL: cal_d = pwdata;
        OFF_BIAS: bias_d = pwdata;
        OFF_AMPCTRL: amp_d[0] = pwdata;
        OFF_AMPOFS: amp_d[1] = pwdata;
        OFF_AMP0MUX: amp_d[2] = pwdata;
        OFF_AMP1MUX: amp_d[3] = pwdata;
        OFF_AMP2MUX: amp_d[4] = pwdata;
        OFF_STATUS, OFF_IF, OFF_IFS, OFF_IFC: ;
        default: unmapped = 1'b1;
      endcase
    end
    data_start = data_start & chan_en;
  end

  // ==========================================================
  // Converter clock divider and refresh timer
  logic [DIV_W-1:0] div_q, div_d;
  logic [5:0] rfr_q, rfr_d;
  logic tick;
  logic [6:0] div_limit;
  assign div_limit = 7'((8'd1 << div_exp) - 8'd1);
  // Enable pulse every 2^exp peripheral cycles.
  assign tick = (div_q >= div_limit);
  logic [5:0] rfr_limit;
  assign rfr_limit = 6'((RFR_BASE << rfr_code) - 1);

  always_comb
  begin
    div_d = tick ? '0 : div_q + 7'd1;
    // Restart divider on channel 0 start.
    if (ctrl_q[CTRL_RST0] && start[0])
      div_d = '0;
    rfr_d = rfr_q;
    rfr_start = 2'b00;
    if (tick)
    begin
      if (rfr_q >= rfr_limit)
      begin
        rfr_d = '0;
        // Refresh only with auto rewrite set.
        rfr_start = {chctl_q[1][CH_RFR], chctl_q[0][CH_RFR]} & chan_en;
      end
      else
        rfr_d = rfr_q + 6'd1;
    end
  end

  // ==========================================================
  // Triggering, pending flags and sine table
  logic [3:0] sine_q, sine_d;
  logic [11:0] sine_val;
  logic sine_mode, sine_line, gate_line;
  assign sine_mode = ctrl_q[CTRL_SINE];
  assign sine_line = ev_sync_q[chctl_q[0][CH_SEL_LO +: 3]];
  assign gate_line = ev_sync_q[chctl_q[1][CH_SEL_LO +: 3]];

  always_comb
  begin
    case (sine_q)
      4'h0: sine_val = 12'h800;
      4'h1: sine_val = 12'hB0F;
      4'h2: sine_val = 12'hDA8;
      4'h3: sine_val = 12'hF64;
      4'h4: sine_val = 12'hFFF;
      4'h5: sine_val = 12'hF64;
      4'h6: sine_val = 12'hDA8;
      4'h7: sine_val = 12'hB0F;
      4'h8: sine_val = 12'h800;
      4'h9: sine_val = 12'h4F0;
      4'hA: sine_val = 12'h257;
      4'hB: sine_val = 12'h09B;
      4'hC: sine_val = 12'h000;
      4'hD: sine_val = 12'h09B;
      4'hE: sine_val = 12'h257;
      default: sine_val = 12'h4F0;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_trig
      // Selected event line for this channel.
      // Event line replaces writes as start source.
      assign trig_start[g] = chctl_q[g][CH_TRIGEN] ? ev_rise[chctl_q[g][CH_SEL_LO +: 3]] : data_start[g];
    end
  endgenerate
  // Nothing starts on a disabled channel.
  assign start = (trig_start | rfr_start) & chan_en;

  always_comb
  begin
    flags_d = flags_q;
    if (wr && paddr == OFF_IFC)
      flags_d = flags_d & ~(pwdata & IF_MASK);
    // Write one sets a flag; hardware set wins below.
    if (wr && paddr == OFF_IFS)
      flags_d = flags_d | (pwdata & IF_MASK);
    flags_d[1:0] = flags_d[1:0] | start;
    // Set on write, cleared on consumption; write wins same cycle.
    pend_d = (pend_q & ~start) | data_start;
    sine_d = sine_q;
    // Advance only while the line is high, else back to zero phase.
    if (!sine_mode || !sine_line)
      sine_d = 4'h0;
    else if (tick)
      sine_d = 4'((sine_q + 4'd1) % SINE_STEPS);
  end

  // Read data is launched from the setup cycle so that it stands while pready is high.
  always_comb
  begin
    prdata_d = prdata;
    if (psel && !penable && !pwrite)
    begin
      case (paddr)
        OFF_CTRL: prdata_d = ctrl_q;
        OFF_STATUS: prdata_d = {30'h0, pend_q};
        OFF_CH0CTRL: prdata_d = chctl_q[0];
        OFF_CH1CTRL: prdata_d = chctl_q[1];
        OFF_IEN: prdata_d = ien_q;
        OFF_IF: prdata_d = flags_q;
        OFF_CH0VAL: prdata_d = {20'h0, val_q[0]};
        OFF_CH1VAL: prdata_d = {20'h0, val_q[1]};
        OFF_CAL: prdata_d = cal_q;
        OFF_BIAS: prdata_d = bias_q;
        OFF_AMPCTRL: prdata_d = amp_q[0];
        OFF_AMPOFS: prdata_d = amp_q[1];
        OFF_AMP0MUX: prdata_d = amp_q[2];
        OFF_AMP1MUX: prdata_d = amp_q[3];
        OFF_AMP2MUX: prdata_d = amp_q[4];
        // Joint register is write-only and reads zero.
        default: prdata_d = 32'h0000_0000;
      endcase
    end
  end
  logic rd_unmapped;
  assign rd_unmapped = rd && !(paddr inside {OFF_CTRL, OFF_STATUS, OFF_CH0CTRL, OFF_CH1CTRL, OFF_IEN, OFF_IF,
    OFF_IFS, OFF_IFC, OFF_CH0VAL, OFF_CH1VAL, OFF_JOINT, OFF_CAL, OFF_BIAS, OFF_AMPCTRL, OFF_AMPOFS,
    OFF_AMP0MUX, OFF_AMP1MUX, OFF_AMP2MUX});

  // ==========================================================
  // State registers and registered outputs
  logic [11:0] src0, src1;
  // Differential mode takes both outputs from channel 0.
  assign src0 = sine_mode ? sine_val : val_d[0];
  assign src1 = ctrl_q[CTRL_DIFFERENTIAL_PAIR] ? src0 : val_d[1];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= CTRL_RESET;
      chctl_q[0] <= 32'h0000_0000;
      chctl_q[1] <= 32'h0000_0000;
      ien_q <= 32'h0000_0000;
      flags_q <= 32'h0000_0000;
      cal_q <= CAL_RESET;
      bias_q <= BIAS_RESET;
      for (int i = 0; i < 5; i++)
        amp_q[i] <= 32'h0000_0000;
      val_q[0] <= 12'h000;
      val_q[1] <= 12'h000;
      pend_q <= 2'b00;
      div_q <= '0;
      rfr_q <= 6'h00;
      sine_q <= 4'h0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      ch0_out <= '0;
      ch1_out <= '0;
      chan_enable <= 2'b00;
      out_enable <= 1'b0;
      output_routing <= 2'h1;
      reference_sel <= REF_BG1V25;
      conversion_style <= CONV_CONTINUOUS;
      differential_pair <= 1'b0;
      converter_clk_en <= 1'b0;
      conv_done <= 2'b00;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      chctl_q <= chctl_d;
      ien_q <= ien_d;
      flags_q <= flags_d;
      cal_q <= cal_d;
      bias_q <= bias_d;
      amp_q <= amp_d;
      val_q <= val_d;
      pend_q <= pend_d;
      div_q <= div_d;
      rfr_q <= rfr_d;
      sine_q <= sine_d;
      prdata <= prdata_d;
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & 1'b0;
      if (psel && !penable)
        pslverr <= 1'b0;
      if (unmapped || rd_unmapped)
        pslverr <= 1'b0;
      ch0_out <= '{pending: pend_d[0], start: start[0], value: src0};
      ch1_out <= '{pending: pend_d[1], start: start[1], value: src1};
      chan_enable <= chan_en;
      // Output enable gated by channel 1 event line.
      out_enable <= ~ctrl_q[CTRL_OUTEN] | gate_line;
      // Routing field to the analog side.
      output_routing <= ctrl_q[CTRL_OUT_LO +: 2];
      reference_sel <= ctrl_q[CTRL_REF_LO +: 2];
      conversion_style <= conv_style_t'(ctrl_q[CTRL_CONV_LO +: 2]);
      differential_pair <= ctrl_q[CTRL_DIFFERENTIAL_PAIR];
      converter_clk_en <= tick;
      conv_done <= start;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_pend_set;
    wr && paddr == OFF_CH0VAL && chan_en[0] && !chctl_q[0][CH_TRIGEN] |=> ch0_out.pending;
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("pending not set");
  property p_ifs;
    wr && paddr == OFF_IFS && pwdata[4] |=> flags_q[4];
  endproperty
  a_ifs: assert property (p_ifs) else $error("flag set failed");
  property p_ifc;
    wr && paddr == OFF_IFC && pwdata[5] && !(wr && paddr == OFF_IFS) |=> !flags_q[5];
  endproperty
  a_ifc: assert property (p_ifc) else $error("flag clear failed");
  property p_disabled;
    !chan_en[1] |=> !ch1_out.start;
  endproperty
  a_disabled: assert property (p_disabled) else $error("start on disabled channel");
  property p_outen;
    !ctrl_q[CTRL_OUTEN] |=> out_enable;
  endproperty
  a_outen: assert property (p_outen) else $error("output enable dropped");
  property p_trig_only;
    chctl_q[0][CH_TRIGEN] && !ev_rise[chctl_q[0][CH_SEL_LO +: 3]] && !rfr_start[0] |=> !ch0_out.start;
  endproperty
  a_trig_only: assert property (p_trig_only) else $error("write started a triggered channel");
  property p_joint;
    wr && paddr == OFF_JOINT && chan_en == 2'b11 && chctl_q[0][2] == 1'b0 && chctl_q[1][2] == 1'b0
      |=> ch0_out.start && ch1_out.start;
  endproperty
  a_joint: assert property (p_joint) else $error("joint write did not start");
  property p_norfr;
    !chctl_q[1][CH_RFR] && !chctl_q[1][CH_TRIGEN] && !data_start[1] |=> !ch1_out.start;
  endproperty
  a_norfr: assert property (p_norfr) else $error("refresh without enable");
  property p_div0;
    div_exp == 4'd0 ##1 div_exp == 4'd0 |-> converter_clk_en [*2];
  endproperty
  a_div0: assert property (p_div0) else $error("divider not every cycle");
  c_joint: cover property (p_joint);
  c_trig: cover property (ch0_out.start && chctl_q[0][CH_TRIGEN]);
  c_rfr: cover property (rfr_start != 2'b00);
  c_sine: cover property (sine_q == 4'hF);
endmodule // dac_digital_control
`default_nettype wire

// ===== tb/dac_digital_control_tb.sv
// Purpose: Self-checking bench for the converter control front end over APB.
// Assumes: Zero-wait APB slave, event lines sampled through a two-flop synchroniser.
// Notes: Random data comes from an LFSR seeded with a fixed value, so runs repeat.
`timescale 1ns/1ps
`default_nettype none
module dac_digital_control_tb
  import dac_ctrl_pkg::*;
;
  // ==========================================================
  // Signals and monitors
  // ==========================================================
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] event_line = 8'h00;
  chan_out_t ch0_out;
  chan_out_t ch1_out;
  logic [1:0] chan_enable;
  logic out_enable;
  logic [1:0] output_routing;
  logic [1:0] reference_sel;
  conv_style_t conversion_style;
  logic differential_pair;
  logic converter_clk_en;
  logic [1:0] conv_done;
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;
  int st0 = 0;
  int st1 = 0;
  int ticks = 0;
  int dn0 = 0;
  int dn1 = 0;
  logic err = 1'b0;
  logic [11:0] v0;
  logic [11:0] v1;
  logic [31:0] rd;
  logic [31:0] lfsr_s = 32'h8E7E;

  always #12.5 pclk = ~pclk;

  dac_digital_control DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_line(event_line), .ch0_out(ch0_out), .ch1_out(ch1_out), .chan_enable(chan_enable),
    .out_enable(out_enable), .output_routing(output_routing), .reference_sel(reference_sel),
    .conversion_style(conversion_style), .differential_pair(differential_pair),
    .converter_clk_en(converter_clk_en), .conv_done(conv_done));

  // Start strobes are single-cycle, so they are counted here rather than polled.
  always @(posedge pclk)
  begin
    cycles++;
    if (ch0_out.start === 1'b1)
    begin
      st0++;
      v0 = ch0_out.value;
    end
    if (ch1_out.start === 1'b1)
    begin
      st1++;
      v1 = ch1_out.value;
    end
    if (converter_clk_en === 1'b1)
      ticks++;
    if (conv_done[0] === 1'b1)
      dn0++;
    if (conv_done[1] === 1'b1)
      dn1++;
    if (cycles > 30000)
    begin
      fails++;
      final_report();
    end
  end

  // ==========================================================
  // Helpers
  // ==========================================================
  function logic [31:0] rnd();
    lfsr_s = {lfsr_s[30:0], lfsr_s[31] ^ lfsr_s[21] ^ lfsr_s[1] ^ lfsr_s[0]};
    return lfsr_s;
  endfunction

  // Refresh period in peripheral cycles: 8 << code divided cycles of 2^e each.
  function automatic int rfr_cycles(input int code, input int e);
    return (RFR_BASE << code) << e;
  endfunction

  // Divided period after a restart, plus the one registered cycle of the enable output.
  function automatic int clk_lat(input int e);
    return (1 << e) + 1;
  endfunction

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // The request is held until pready is sampled high; the bench never assumes a latency.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 20)
      fails++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd_chk(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask

  task final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    logic [31:0] d;
    logic [11:0] v;
    logic [11:0] a;
    int s0;
    int s1;
    int t0;
    int per;
    int n;
    cyc(3);
    presetn <= 1'b1;
    rd_chk(OFF_CTRL, CTRL_RESET, "ctrl reset");
    rd_chk(OFF_STATUS, 32'h0, "status reset");
    rd_chk(OFF_CH0CTRL, 32'h0, "ch0ctrl reset");
    rd_chk(OFF_IF, 32'h0, "flags reset");
    chk("routing reset", {30'h0, output_routing}, 32'h1);
    chk("style reset", {30'h0, conversion_style}, 32'h0);
    chk("ref reset", {30'h0, reference_sel}, 32'h0);
    rd_chk(12'h040, 32'h0, "unmapped read");
    chk("no error", {31'h0, err}, 32'h0);
    apb(1'b1, OFF_AMP2MUX, 32'h1234_5678);
    rd_chk(OFF_AMP2MUX, 32'h1234_5678, "amp2 mux readback");
    // Every routing, style and reference code.
    for (int i = 0; i < 4; i++)
    begin
      d = (rnd() & 32'h0037_0083) | (32'(i) << 4) | (32'(i % 3) << 2) | (32'(i % 3) << 8);
      apb(1'b1, OFF_CTRL, d);
      rd_chk(OFF_CTRL, d, "ctrl readback");
      chk("routing", {30'h0, output_routing}, 32'(i));
      chk("style", {30'h0, conversion_style}, 32'(i % 3));
      chk("reference", {30'h0, reference_sel}, 32'(i % 3));
      d = rnd() & CH_MASK;
      apb(1'b1, OFF_CH1CTRL, d);
      rd_chk(OFF_CH1CTRL, d, "ch1ctrl readback");
    end
    apb(1'b1, OFF_CTRL, CTRL_RESET);
    apb(1'b1, OFF_CH1CTRL, 32'h0);
    // Only the selected line may start channel 0; a data write must not.
    for (int k = 0; k < 8; k++)
    begin
      apb(1'b1, OFF_CH0CTRL, 32'h5 | (32'(k) << 4));
      v = rnd() & VAL_MASK;
      s0 = st0;
      apb(1'b1, OFF_CH0VAL, {20'h0, v});
      rd_chk(OFF_STATUS, 32'h1, "pending set");
      chk("no start on write", 32'(st0), 32'(s0));
      event_line <= ~(8'h01 << k);
      @(posedge pclk);
      event_line <= 8'h00;
      cyc(10);
      chk("other lines ignored", 32'(st0), 32'(s0));
      event_line <= 8'h01 << k;
      @(posedge pclk);
      event_line <= 8'h00;
      n = 0;
      while (st0 == s0 && n < 20)
      begin
        @(posedge pclk);
        n++;
      end
      chk("event start", 32'(st0), 32'(s0 + 1));
      chk("event value", {20'h0, v0}, {20'h0, v});
      cyc(2);
      rd_chk(OFF_STATUS, 32'h0, "pending consumed");
    end
    // Joint write starts both enabled channels; a disabled channel stays silent.
    apb(1'b1, OFF_CH0CTRL, 32'h1);
    apb(1'b1, OFF_CH1CTRL, 32'h1);
    d = rnd() & 32'h0FFF_0FFF;
    s0 = st0;
    s1 = st1;
    apb(1'b1, OFF_JOINT, d);
    cyc(10);
    chk("joint ch0 start", 32'(st0), 32'(s0 + 1));
    chk("joint ch1 start", 32'(st1), 32'(s1 + 1));
    chk("joint ch0 value", {20'h0, v0}, {20'h0, d[11:0]});
    chk("joint ch1 value", {20'h0, v1}, {20'h0, d[27:16]});
    chk("both enabled", {30'h0, chan_enable}, 32'h3);
    rd_chk(OFF_JOINT, 32'h0, "joint reads zero");
    apb(1'b1, OFF_CH1CTRL, 32'h0);
    s1 = st1;
    apb(1'b1, OFF_CH1VAL, rnd() & VAL_MASK);
    cyc(10);
    chk("disabled ch1", 32'(st1), 32'(s1));
    chk("ch1 enable low", {30'h0, chan_enable}, 32'h1);
    // Differential pair mirrors the channel 0 value onto channel 1.
    apb(1'b1, OFF_CTRL, CTRL_RESET | 32'h1);
    v = rnd() & VAL_MASK;
    apb(1'b1, OFF_CH0VAL, {20'h0, v});
    cyc(4);
    chk("differential_pair value", {20'h0, ch1_out.value}, {20'h0, v});
    chk("differential_pair flag", {31'h0, differential_pair}, 32'h1);
    // Flag set and clear registers, including a write of zero to the clear register.
    apb(1'b1, OFF_CTRL, CTRL_RESET);
    apb(1'b1, OFF_IFC, IF_MASK);
    rd_chk(OFF_IF, 32'h0, "flags cleared");
    apb(1'b1, OFF_IFS, 32'h10);
    rd_chk(OFF_IF, 32'h10, "flag set");
    apb(1'b1, OFF_IFS, 32'h20);
    rd_chk(OFF_IF, 32'h30, "flag set keeps");
    apb(1'b1, OFF_IFC, 32'h10);
    rd_chk(OFF_IF, 32'h20, "flag clear");
    apb(1'b1, OFF_IFC, 32'h0);
    rd_chk(OFF_IF, 32'h20, "clear zero");
    // Output gating follows channel 1's selected line only when enabled.
    apb(1'b1, OFF_CH1CTRL, 32'h35);
    apb(1'b1, OFF_CTRL, CTRL_RESET | 32'h40);
    cyc(8);
    chk("gated low", {31'h0, out_enable}, 32'h0);
    event_line <= 8'h08;
    cyc(8);
    chk("gated high", {31'h0, out_enable}, 32'h1);
    apb(1'b1, OFF_CTRL, CTRL_RESET);
    event_line <= 8'h00;
    cyc(8);
    chk("ungated", {31'h0, out_enable}, 32'h1);
    apb(1'b1, OFF_CH1CTRL, 32'h0);
    // Divider restart makes the first divided tick after a channel 0 start land at a fixed cycle.
    apb(1'b1, OFF_CH0CTRL, 32'h1);
    apb(1'b1, OFF_CTRL, CTRL_RESET | 32'h0003_0080);
    repeat (2)
    begin
      cyc(int'(rnd() & 32'h7) + 1);
      apb(1'b1, OFF_CH0VAL, rnd() & VAL_MASK);
      cyc(1);
      n = 1;
      do
      begin
        @(posedge pclk);
        n++;
      end
      while (converter_clk_en !== 1'b1 && n < 40);
      chk("restart latency", 32'(n), 32'(clk_lat(3)));
    end
    // Sine table: midscale while the line is low, 16-step period while high.
    apb(1'b1, OFF_CH0CTRL, 32'h21);
    apb(1'b1, OFF_CTRL, CTRL_RESET | 32'h2);
    cyc(5);
    chk("sine idle", {20'h0, ch0_out.value}, 32'h800);
    event_line <= 8'h04;
    cyc(6);
    a = ch0_out.value;
    cyc(SINE_STEPS);
    chk("sine period", {20'h0, ch0_out.value}, {20'h0, a});
    cyc(1);
    chk("sine advances", {31'h0, ch0_out.value != a}, 32'h1);
    event_line <= 8'h00;
    apb(1'b1, OFF_CTRL, CTRL_RESET);
    // Refresh period per code and divider rate; triggers are held off by the event line.
    apb(1'b1, OFF_CH0CTRL, 32'h7);
    for (int c = 0; c < 4; c++)
    begin
      per = rfr_cycles(c, c & 1);
      apb(1'b1, OFF_CTRL, CTRL_RESET | (32'(c) << 20) | (32'(c & 1) << 16));
      cyc(per);
      s0 = st0;
      t0 = ticks;
      cyc(per * 10);
      chk("refresh count", {31'h0, (st0 - s0 >= 9) && (st0 - s0 <= 11)}, 32'h1);
      chk("divided ticks", {31'h0, (ticks - t0 >= (80 << c) - 1) && (ticks - t0 <= (80 << c) + 1)}, 32'h1);
    end
    apb(1'b1, OFF_CH0CTRL, 32'h5);
    cyc(8);
    s0 = st0;
    cyc(100);
    chk("no refresh", 32'(st0), 32'(s0));
    chk("done count ch0", 32'(dn0), 32'(st0));
    chk("done count ch1", 32'(dn1), 32'(st1));
    final_report();
  end
endmodule // dac_digital_control_tb
`default_nettype wire
